//--- dv/gdspi_master.sv
`timescale 1ns/1ps
// controller model, mode 0; its clock stands still low between frames
module gdspi_master (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe_n
);
    logic miso_hold;
    logic miso;
    // no pull on miso, so a released line shows the inverse of the last bit
    always @(miso_out or miso_oe_n) begin
        if (!miso_oe_n) begin
            miso_hold = miso_out;
        end
    end
    assign miso = miso_oe_n ? ~miso_hold : miso_out;
    // mosi has a pull-up, idle level high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end
    // one select-low period of n clocks with no gaps, msb first
    task automatic xfer(input int n, input logic [71:0] d, output logic [71:0] q);
        q = '0;
        cs_n = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = d[i];
            #100 sclk = 1'b1;
            #90 q = {q[70:0], miso};
            #10 sclk = 1'b0;
        end
        #100 cs_n = 1'b1;
        mosi = 1'b1;
        #300;
    endtask
endmodule

//--- dv/gdspi_monitor.sv
`timescale 1ns/1ps
// pin-level checker of the serial port and the programming sequencer
module gdspi_monitor #(
    parameter int PROG_TIMEOUT_CYC = 2000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic miso_oe_n,
    input wire logic primary_pg,
    input wire gdspi_pkg::gdspi_ecc_s ecc,
    input wire logic ee_start,
    input wire logic ee_done,
    input wire logic ee_ok,
    input wire logic sim_apply,
    input wire logic prog_busy,
    input wire logic shutdown
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic [5:0] tries;
    int busy_run;
    // attempts of the current run; the first start and busy rise in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn || (!prog_busy && !ee_start)) begin
            tries <= 6'h00;
        end else if (ee_start) begin
            tries <= tries + 6'h01;
        end
    end
    // length of the busy run, too long to unroll as a repetition
    always_ff @(posedge clk) begin
        if (!rstn || !prog_busy) begin
            busy_run <= 0;
        end else begin
            busy_run <= busy_run + 1;
        end
    end
    a_oe_released: assert property (cs_n [*8] |-> miso_oe_n)
        else $error("miso driven with select high");
    a_oe_unpowered: assert property (!primary_pg [*8] |-> miso_oe_n)
        else $error("miso driven without primary power");
    a_sim_one_shot: assert property (sim_apply |=> !sim_apply)
        else $error("apply pulse longer than one cycle");
    a_start_busy: assert property (ee_start |=> prog_busy)
        else $error("attempt started while not busy");
    a_retry_next: assert property (prog_busy && ee_done && !ee_ok && tries < 6'h28 |=> ee_start)
        else $error("failed attempt not retried");
    a_try_limit: assert property (tries <= 6'h28)
        else $error("more than forty attempts");
    a_fail_stop: assert property (prog_busy && ee_done && !ee_ok && tries == 6'h28 |-> ##[1:2] !prog_busy)
        else $error("busy after last failed attempt");
    a_ok_stop: assert property (prog_busy && ee_done && ee_ok |-> ##[1:2] !prog_busy)
        else $error("busy after successful attempt");
    a_busy_bound: assert property (busy_run <= PROG_TIMEOUT_CYC + 4)
        else $error("programming exceeds time bound");
    a_shut_hold: assert property (shutdown |=> shutdown)
        else $error("shutdown released without reset");
    a_uncorr_shut: assert property (ecc.ee_uncorr |-> ##[1:4] shutdown)
        else $error("uncorrectable error without shutdown");
    c_apply: cover property (sim_apply);
    c_start: cover property (ee_start);
    c_shut: cover property (shutdown);
    c_drive: cover property (!miso_oe_n);
endmodule

bind gdspi_port gdspi_monitor #(.PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC)) gdspi_monitor_i (.clk(clk), .rstn(rstn),
    .cs_n(cs_n), .miso_oe_n(miso_oe_n), .primary_pg(primary_pg), .ecc(ecc), .ee_start(ee_start),
    .ee_done(ee_done), .ee_ok(ee_ok), .sim_apply(sim_apply), .prog_busy(prog_busy), .shutdown(shutdown));

//--- dv/gdspi_port_test.sv
`timescale 1ns/1ps
// table of plain frames, then hand-written awkward cases
module gdspi_port_test;
    localparam int TO_CYC = 2000;
    localparam logic [11:0] TS = 12'hA5C;
    localparam logic [11:0] DIE = 12'h3C1;
    logic clk;
    logic rstn;
    logic primary_pg, secondary_pg;
    logic ee_done = 1'b0;
    logic ee_ok = 1'b0;
    gdspi_pkg::gdspi_ecc_s ecc;
    wire sclk, cs_n, mosi, miso_out, miso_oe_n, ee_start, sim_apply, prog_busy, shutdown;
    int err_count, checks_done, cyc, starts, sims, ecnt, okat, dly;
    logic [71:0] q;
    logic [47:0] rows [8];

    gdspi_port #(.PROG_TIMEOUT_CYC(TO_CYC)) gdspi_port_i (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .primary_pg(primary_pg),
        .secondary_pg(secondary_pg), .ecc(ecc), .ts_duty(TS), .die_duty(DIE), .ee_start(ee_start),
        .ee_done(ee_done), .ee_ok(ee_ok), .sim_apply(sim_apply), .prog_busy(prog_busy), .shutdown(shutdown));
    gdspi_master gdspi_master_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // memory stand-in: each attempt ends 8 cycles after its start
    always @(negedge clk) begin
        ee_done <= 1'b0;
        if (ee_start === 1'b1) begin
            ecnt <= ecnt + 1;
            dly <= 8;
        end else if (dly > 0) begin
            dly <= dly - 1;
            ee_done <= (dly == 1);
            ee_ok <= (ecnt >= okat);
        end
    end

    // pulse counts and hang guard
    always @(posedge clk) begin
        starts += (ee_start === 1'b1);
        sims += (sim_apply === 1'b1);
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            test_done();
        end
    end

    // frame with its check byte, computed bit by bit msb first
    function automatic logic [23:0] fr(input logic [15:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
        return {v, c};
    endfunction

    task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // start off the clock grid so every link edge falls 7 ns after a clk edge
    task automatic x(input int n, input logic [71:0] d);
        @(negedge clk);
        #7;
        gdspi_master_i.xfer(n, d, q);
    endtask

    // answer seen in a frame belongs to the previous command
    task automatic f(input logic [23:0] c, input logic [23:0] e, input bit k);
        x(24, {48'h0, c});
        if (k) chk("response", q[23:0], e);
    endtask

    task automatic idle();
        for (int i = 0; i < 4000 && prog_busy !== 1'b0; i++) @(negedge clk);
    endtask

    task automatic test_done();
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        primary_pg = 1'b1;
        secondary_pg = 1'b1;
        ecc = '0;
        okat = 999;
        rows = '{{fr(16'h4200), fr(16'h0100)}, {fr(16'hC203), fr(16'h4200)}, {fr(16'h0800), fr(16'hC203)},
            {fr(16'h0900), fr({4'h0, TS})}, {fr(16'hC205), fr({4'h0, DIE})}, {fr(16'h4200), fr(16'hC205)},
            {fr(16'h3000), fr(16'h4201)}, {fr(16'h0100), fr(16'h3000)}};
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        x(24, {48'h0, fr(16'hC203)});
        f(fr(16'h0100), 24'h0, 0);
        for (int i = 0; i < 8; i++) f(rows[i][47:24], rows[i][23:0], 1);
        chk("apply", sims, 1);
        f(fr(16'hC207) ^ 24'h1, fr(16'h0100), 1);
        f(fr(16'h0100), 24'h0, 0);
        f(fr(16'h4200), fr(16'h0102), 1);
        chk("starts", starts, 0);
        x(23, {48'h0, fr(16'h4100)});
        f(fr(16'h0100), 24'h0, 1);
        f(fr(16'h4100), fr(16'h0103), 1);
        f(fr(16'h4200), fr(16'h4101), 1);
        x(48, {24'h0, fr(16'h4200), fr(16'hC203)});
        chk("echo", q[23:0], fr(16'h4200));
        chk("lead", q[47:24], fr(16'h4201));
        f(fr(16'h0100), fr(16'hC203), 1);
        chk("apply", sims, 2);
        @(negedge clk) ecc = 3'b110;
        @(negedge clk) ecc = '0;
        f(fr(16'h4100), fr(16'h0103), 1);
        f(fr(16'h0100), fr(16'h4103), 1);
        f(fr(16'h0100), fr(16'h0107), 1);
        chk("shutdown", shutdown, 0);
        f(fr(16'hC207), fr(16'h0107), 1);
        f(fr(16'h4200), 24'h0, 0);
        idle();
        f(fr(16'h4100), fr(16'h4207), 1);
        f(fr(16'h4200), fr(16'h410B), 1);
        chk("starts", starts, 40);
        okat = ecnt + 3;
        f(fr(16'hC207), fr(16'h4203), 1);
        idle();
        chk("starts", starts, 43);
        secondary_pg = 1'b0;
        f(fr(16'hC203), 24'h0, 0);
        f(fr(16'h4200), 24'h0, 0);
        f(fr(16'h0100), 24'h000000, 1);
        f(fr(16'h0100), fr(16'h0107), 1);
        chk("apply", sims, 2);
        @(negedge clk) secondary_pg = 1'b1;
        primary_pg = 1'b0;
        repeat (8) @(negedge clk);
        x(24, {48'h0, fr(16'hC203)});
        chk("apply", sims, 2);
        primary_pg = 1'b1;
        repeat (8) @(negedge clk);
        x(0, 72'h0);
        @(negedge clk) ecc = 3'b001;
        @(negedge clk) ecc = '0;
        repeat (8) @(negedge clk);
        chk("shutdown", shutdown, 1);
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        chk("reset", {shutdown, prog_busy, miso_oe_n, sim_apply, ee_start}, 5'h04);
        rstn = 1'b1;
        test_done();
    end
endmodule

//--- src/gdspi_pkg.sv
package gdspi_pkg;

    // frame geometry and check byte
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // register addresses, seven bits; bit 6 set means the secondary die
    localparam logic [6:0] ADDR_PRI_STATUS = 7'h01;
    localparam logic [6:0] ADDR_TS_DUTY = 7'h08;
    localparam logic [6:0] ADDR_DIE_DUTY = 7'h09;
    localparam logic [6:0] ADDR_SEC_STATUS = 7'h41;
    localparam logic [6:0] ADDR_SEC_CTRL = 7'h42;
    localparam int SEC_SPACE_BIT = 6;

    // primary_die status bits
    localparam int PST_COMM = 0;
    localparam int PST_CRC = 1;
    localparam int PST_FUSE_ECC = 2;
    // secondary_die status bits
    localparam int SST_COMM = 0;
    localparam int SST_ECC_FIXED = 1;
    localparam int SST_ECC_UNCORR = 2;
    localparam int SST_PROG_FAIL = 3;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // secondary_program_control action codes in bits 2..0
    localparam logic [2:0] CTRL_SIMULATE = 3'h3;
    localparam logic [2:0] CTRL_PROGRAM = 3'h7;
    localparam int CTRL_BUSY_BIT = 2;

    // programming sequence limits
    localparam logic [5:0] PROG_MAX_ATTEMPTS = 6'h28;
    localparam int PROG_TIME_MS = 40;
    localparam int CLK_HZ = 40000000;
    localparam int PROG_TIMEOUT_CYC = PROG_TIME_MS * (CLK_HZ / 1000);
    localparam int PROG_TIMER_W = 21;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
        logic [7:0] crc;
    } gdspi_frame_s;

    typedef struct packed {
        logic fuse_err;
        logic ee_fixed;
        logic ee_uncorr;
    } gdspi_ecc_s;

    typedef enum logic {
        PROG_IDLE = 1'b0,
        PROG_WAIT = 1'b1
    } gdspi_prog_e;

    // crc-8, polynomial x^8+x^2+x+1, msb first, zero seed
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

endpackage

//--- src/gdspi_port.sv
`timescale 1ns/1ps
module gdspi_port #(
    parameter int PROG_TIMEOUT_CYC = gdspi_pkg::PROG_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso_out,
    output logic miso_oe_n,
    input wire logic primary_pg,
    input wire logic secondary_pg,
    input wire gdspi_pkg::gdspi_ecc_s ecc,
    input wire logic [11:0] ts_duty,
    input wire logic [11:0] die_duty,
    output logic ee_start,
    input wire logic ee_done,
    input wire logic ee_ok,
    output logic sim_apply,
    output logic prog_busy,
    output logic shutdown
);

    logic [4:0] pin_q;
    logic sclk_s, cs_s, mosi_s, pri_s, sec_s;
    logic sclk_d_reg, cs_d_reg;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall;
    logic armed_reg, active_reg;
    logic [23:0] shift_reg;
    logic [23:0] resp_reg;
    logic [23:0] resp_next;
    logic [4:0] cnt_reg;
    logic any_clk_reg;
    logic [7:0] pri_status_reg, sec_status_reg, ctrl_reg;
    logic miso_reg, miso_oe_n_reg;
    logic ee_start_reg, sim_apply_reg, shutdown_reg;
    gdspi_pkg::gdspi_prog_e prog_state_reg;
    logic [5:0] attempts_reg;
    logic [gdspi_pkg::PROG_TIMER_W-1:0] timer_reg;
    gdspi_pkg::gdspi_frame_s cmd;
    logic take, framing_ok, exec, crc_ok, wr_go, sec_block, busy;
    logic comm_ev, crc_ev, prog_fail_ev, prog_req;
    logic [7:0] pri_clr, sec_clr, rdata;

    // pins and power-good levels come from other domains
    // select travels inverted so a cleared chain reads as idle high: no false select edge after reset
    gdspi_sync #(
        .W(5)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({sclk, ~cs_n, mosi, primary_pg, secondary_pg}),
        .q(pin_q)
    );

    assign sclk_s = pin_q[4];
    assign cs_s = ~pin_q[3];
    assign mosi_s = pin_q[2];
    assign pri_s = pin_q[1];
    assign sec_s = pin_q[0];

    // edge history; select idles high so its history starts high
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_d_reg <= cs_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign cs_rise = cs_s & ~cs_d_reg;
    assign cs_fall = ~cs_s & cs_d_reg;

    // arming waits for the first select rise after primary power is good
    always_ff @(posedge clk) begin
        if (!rstn) begin
            armed_reg <= 1'b0;
        end else if (!pri_s) begin
            armed_reg <= 1'b0;
        end else if (cs_rise) begin
            armed_reg <= 1'b1;
        end
    end

    // a frame is live from select fall to select rise
    always_ff @(posedge clk) begin
        if (!rstn) begin
            active_reg <= 1'b0;
        end else if (!pri_s || cs_rise) begin
            active_reg <= 1'b0;
        end else if (cs_fall && armed_reg) begin
            active_reg <= 1'b1;
        end
    end

    // one register both carries the response out and the stream in, which gives the 24-bit repeat delay
    always_ff @(posedge clk) begin
        if (!rstn) begin
            shift_reg <= 24'h000000;
        end else if (cs_fall && armed_reg && pri_s) begin
            shift_reg <= resp_reg;
        end else if (sclk_rise && active_reg) begin
            shift_reg <= {shift_reg[22:0], mosi_s};
        end
    end

    // bit counter modulo one frame; any_clk tells zero clocks from 24n clocks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= 5'h00;
            any_clk_reg <= 1'b0;
        end else if (cs_fall) begin
            cnt_reg <= 5'h00;
            any_clk_reg <= 1'b0;
        end else if (sclk_rise && active_reg) begin
            any_clk_reg <= 1'b1;
            if (cnt_reg == gdspi_pkg::FRAME_LAST) begin
                cnt_reg <= 5'h00;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // serial output and its enable, released while select is high
    always_ff @(posedge clk) begin
        if (!rstn) begin
            miso_reg <= 1'b0;
            miso_oe_n_reg <= 1'b1;
        end else if (!pri_s || cs_rise || cs_s) begin
            miso_oe_n_reg <= 1'b1;
        end else if (cs_fall && armed_reg) begin
            miso_reg <= resp_reg[23];
            miso_oe_n_reg <= 1'b0;
        end else if (sclk_fall && active_reg) begin
            miso_reg <= shift_reg[23];
        end
    end

    // command decode at select rise
    assign cmd = gdspi_pkg::gdspi_frame_s'(shift_reg);
    assign take = active_reg & cs_rise;
    assign framing_ok = (cnt_reg == 5'h00);
    assign exec = take & framing_ok & any_clk_reg;
    assign comm_ev = take & ~framing_ok;
    assign crc_ok = (gdspi_pkg::crc8(shift_reg[23:8]) == cmd.crc);
    assign crc_ev = exec & cmd.wr & ~crc_ok;
    assign sec_block = cmd.addr[gdspi_pkg::SEC_SPACE_BIT] & ~sec_s;
    assign wr_go = exec & cmd.wr & crc_ok & ~sec_block;
    assign busy = (prog_state_reg == gdspi_pkg::PROG_WAIT);
    assign prog_req = wr_go && cmd.addr == gdspi_pkg::ADDR_SEC_CTRL && cmd.data[2:0] == gdspi_pkg::CTRL_PROGRAM;

    // write-one-to-clear masks for the status registers
    assign pri_clr = (wr_go && cmd.addr == gdspi_pkg::ADDR_PRI_STATUS) ? cmd.data : 8'h00;
    assign sec_clr = (wr_go && cmd.addr == gdspi_pkg::ADDR_SEC_STATUS) ? cmd.data : 8'h00;

    // primary status; set is ored after the clear so a same-cycle event survives
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pri_status_reg <= gdspi_pkg::STATUS_RESET;
        end else begin
            pri_status_reg <= pri_status_reg & ~pri_clr;
            pri_status_reg[gdspi_pkg::PST_COMM] <= (pri_status_reg[gdspi_pkg::PST_COMM]
                & ~pri_clr[gdspi_pkg::PST_COMM]) | comm_ev;
            pri_status_reg[gdspi_pkg::PST_CRC] <= (pri_status_reg[gdspi_pkg::PST_CRC]
                & ~pri_clr[gdspi_pkg::PST_CRC]) | crc_ev;
            pri_status_reg[gdspi_pkg::PST_FUSE_ECC] <= (pri_status_reg[gdspi_pkg::PST_FUSE_ECC]
                & ~pri_clr[gdspi_pkg::PST_FUSE_ECC]) | ecc.fuse_err;
        end
    end

    // secondary status, same set-wins scheme
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sec_status_reg <= gdspi_pkg::STATUS_RESET;
        end else begin
            sec_status_reg <= sec_status_reg & ~sec_clr;
            sec_status_reg[gdspi_pkg::SST_COMM] <= (sec_status_reg[gdspi_pkg::SST_COMM]
                & ~sec_clr[gdspi_pkg::SST_COMM]) | comm_ev;
            sec_status_reg[gdspi_pkg::SST_ECC_FIXED] <= (sec_status_reg[gdspi_pkg::SST_ECC_FIXED]
                & ~sec_clr[gdspi_pkg::SST_ECC_FIXED]) | ecc.ee_fixed;
            sec_status_reg[gdspi_pkg::SST_ECC_UNCORR] <= (sec_status_reg[gdspi_pkg::SST_ECC_UNCORR]
                & ~sec_clr[gdspi_pkg::SST_ECC_UNCORR]) | ecc.ee_uncorr;
            sec_status_reg[gdspi_pkg::SST_PROG_FAIL] <= (sec_status_reg[gdspi_pkg::SST_PROG_FAIL]
                & ~sec_clr[gdspi_pkg::SST_PROG_FAIL]) | prog_fail_ev;
        end
    end

    // control register keeps what was written; bit 2 is replaced by the busy state on read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_reg <= gdspi_pkg::CTRL_RESET;
        end else if (wr_go && cmd.addr == gdspi_pkg::ADDR_SEC_CTRL) begin
            ctrl_reg <= cmd.data;
        end
    end

    // apply-without-storing pulse only for the exact code
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sim_apply_reg <= 1'b0;
        end else begin
            sim_apply_reg <= wr_go && cmd.addr == gdspi_pkg::ADDR_SEC_CTRL
                && cmd.data[2:0] == gdspi_pkg::CTRL_SIMULATE;
        end
    end

    // uncorrectable eeprom error latches shutdown until reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            shutdown_reg <= 1'b0;
        end else if (ecc.ee_uncorr) begin
            shutdown_reg <= 1'b1;
        end
    end

    // programming sequencer: retries until ok, attempt limit or overall time limit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prog_state_reg <= gdspi_pkg::PROG_IDLE;
            attempts_reg <= 6'h00;
            timer_reg <= '0;
            ee_start_reg <= 1'b0;
            prog_fail_ev <= 1'b0;
        end else begin
            ee_start_reg <= 1'b0;
            prog_fail_ev <= 1'b0;
            unique case (prog_state_reg)
                gdspi_pkg::PROG_IDLE: begin
                    if (prog_req) begin
                        prog_state_reg <= gdspi_pkg::PROG_WAIT;
                        attempts_reg <= 6'h01;
                        timer_reg <= '0;
                        ee_start_reg <= 1'b1;
                    end
                end
                gdspi_pkg::PROG_WAIT: begin
                    timer_reg <= timer_reg + 1'b1;
                    if (timer_reg == gdspi_pkg::PROG_TIMER_W'(PROG_TIMEOUT_CYC - 1)) begin
                        prog_state_reg <= gdspi_pkg::PROG_IDLE;
                        prog_fail_ev <= 1'b1;
                    end else if (ee_done && ee_ok) begin
                        prog_state_reg <= gdspi_pkg::PROG_IDLE;
                    end else if (ee_done && attempts_reg == gdspi_pkg::PROG_MAX_ATTEMPTS) begin
                        prog_state_reg <= gdspi_pkg::PROG_IDLE;
                        prog_fail_ev <= 1'b1;
                    end else if (ee_done) begin
                        attempts_reg <= attempts_reg + 6'h01;
                        ee_start_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // read data for byte registers; unpowered secondary space reads zero
    always_comb begin
        rdata = 8'h00;
        if (!sec_block) begin
            unique case (cmd.addr)
                gdspi_pkg::ADDR_PRI_STATUS: rdata = pri_status_reg;
                gdspi_pkg::ADDR_SEC_STATUS: rdata = sec_status_reg;
                gdspi_pkg::ADDR_SEC_CTRL: begin
                    rdata = ctrl_reg;
                    rdata[gdspi_pkg::CTRL_BUSY_BIT] = busy;
                end
                default: rdata = 8'h00;
            endcase
        end
    end

    // response word; writes echo the command, aborted frames answer zero
    always_comb begin
        resp_next = 24'h000000;
        if (!cmd.wr && sec_block) begin
            resp_next[23:8] = 16'h0000;
        end else if (!cmd.wr && (cmd.addr == gdspi_pkg::ADDR_TS_DUTY || cmd.addr == gdspi_pkg::ADDR_DIE_DUTY)) begin
            resp_next[19:8] = (cmd.addr == gdspi_pkg::ADDR_TS_DUTY) ? ts_duty : die_duty;
        end else if (!cmd.wr) begin
            resp_next[23:8] = {cmd.wr, cmd.addr, rdata};
        end else begin
            resp_next[23:8] = shift_reg[23:8];
        end
        resp_next[7:0] = gdspi_pkg::crc8(resp_next[23:8]);
    end

    // response is fixed at select rise and held for the next select-low period
    always_ff @(posedge clk) begin
        if (!rstn) begin
            resp_reg <= 24'h000000;
        end else if (exec) begin
            resp_reg <= resp_next;
        end else if (comm_ev) begin
            resp_reg <= 24'h000000;
        end
    end

    assign miso_out = miso_reg;
    assign miso_oe_n = miso_oe_n_reg;
    assign ee_start = ee_start_reg;
    assign sim_apply = sim_apply_reg;
    assign prog_busy = busy;
    assign shutdown = shutdown_reg;

endmodule

//--- src/gdspi_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous pins; only the second stage is visible
module gdspi_sync #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // first stage feeds the second and nothing else
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule
